// ### rtl/dcc_pkg.sv
package dcc_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [11:0] DCC_CFG_OFS = 12'h0000;
   localparam logic [11:0] DCC_IRQ_STATUS_OFS = 12'h0004;
   localparam logic [11:0] DCC_IRQ_MASK_OFS = 12'h0008;
   localparam logic [11:0] DCC_CORE_CTRL_OFS = 12'h000C;
   localparam logic [11:0] DCC_WAKE_OFS = 12'h0010;
   // ****************************************
   // configuration field positions
   // ****************************************
   localparam int DCC_MODE_LSB = 0;
   localparam int DCC_SWITCH_BIT = 3;
   localparam int DCC_INV1_BIT = 4;
   localparam int DCC_INV2_BIT = 5;
   localparam int DCC_OUT1_BIT = 6;
   localparam int DCC_OUT2_BIT = 7;
   // core control bits
   localparam int DCC_IE1_BIT = 0;
   localparam int DCC_IE2_BIT = 1;
   localparam int DCC_PERIPHERAL_IRQ_MASTER_ENABLE_BIT = 2;
   localparam int DCC_GIE_BIT = 3;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] DCC_CFG_RST = 8'h00;
   localparam logic [3:0] DCC_CORE_CTRL_RST = 4'h0;
   localparam logic [1:0] DCC_MASK_RST = 2'h0;
   // ****************************************
   // modes of the mode_select_field
   // ****************************************
   typedef enum logic [2:0] {
      DCC_MODE_RESET = 3'h0,
      DCC_MODE_C1_MUX = 3'h1,
      DCC_MODE_MUX_BOTH = 3'h2,
      DCC_MODE_COMMON_REF = 3'h3,
      DCC_MODE_INDEP = 3'h4,
      DCC_MODE_C2_ONLY = 3'h5,
      DCC_MODE_OUT_PINS = 3'h6,
      DCC_MODE_OFF = 3'h7
   } dcc_mode_t;
   // wake sequencing states
   typedef enum logic [2:0] {
      DCC_ST_RUN = 3'b001,
      DCC_ST_NEXT = 3'b010,
      DCC_ST_VEC = 3'b100
   } dcc_state_t;
endpackage : dcc_pkg

// ### rtl/dcc_top.sv
// Function
// - enabled comparator keeps running and updating output during sleep
// - modes 000 and 111 switch both comparators off
// - output change in sleep wakes core if its enable and peripheral_irq_master_enable set
// - after comparator wake core executes instruction after sleep first
// - with gie set core then branches to interrupt routine
// - any reset returns control registers to reset values, mode 000
// - reset mode: all inputs analog, buffers off, comparators disabled
// - second invert bit 5 inverts reported second output
// - mode 110 drives comparator outputs onto dedicated pins
// - flag set while sampled output differs from latched reference
// - every config read or write reloads reference latch
module dcc_top (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog comparator cores
   input wire logic [1:0] raw_compare,
   output logic [1:0] comp_enable,
   output logic [1:0] noninv_sel,
   output logic [1:0] inv_sel,
   output logic ref_to_c2_inv,
   output logic [3:0] analog_pin_mode,
   // dedicated comparator output pins
   output logic [1:0] comp_pin_out,
   output logic [1:0] comp_pin_oe_n,
   // processor core
   input wire logic core_sleeping,
   output logic core_wake,
   output logic core_exec_next,
   output logic core_vector,
   output logic irq
);
   import dcc_pkg::*;

   // ****************************************
   // registers
   // ****************************************
   logic [5:0] ctrl_reg;
   logic [3:0] core_ctrl_reg;
   logic [1:0] status_reg, status_next;
   logic [1:0] mask_reg;
   logic [1:0] sync1_reg, sync2_reg;
   logic [1:0] sample_reg;
   logic [1:0] ref_reg;
   logic wake_seen_reg;
   dcc_state_t state_reg, state_next;

   // ****************************************
   // bus decode
   // ****************************************
   wire logic access = psel && penable;
   wire logic wr = access && pwrite;
   wire logic hit_cfg = paddr == DCC_CFG_OFS;
   wire logic hit_sts = paddr == DCC_IRQ_STATUS_OFS;
   wire logic hit_msk = paddr == DCC_IRQ_MASK_OFS;
   wire logic hit_ctl = paddr == DCC_CORE_CTRL_OFS;
   wire logic hit_wak = paddr == DCC_WAKE_OFS;
   wire logic hit_any = hit_cfg | hit_sts | hit_msk | hit_ctl | hit_wak;
   // writes include a read of the configuration register
   wire logic cfg_touch = access && hit_cfg;

   // ****************************************
   // mode decode
   // ****************************************
   wire dcc_mode_t mode = dcc_mode_t'(ctrl_reg[DCC_MODE_LSB +: 3]);
   wire logic sw = ctrl_reg[DCC_SWITCH_BIT];

   function automatic logic [1:0] mode_enables(input dcc_mode_t m);
      unique case (m)
         DCC_MODE_RESET, DCC_MODE_OFF: mode_enables = 2'h0;
         DCC_MODE_C1_MUX: mode_enables = 2'h1;
         DCC_MODE_C2_ONLY: mode_enables = 2'h2;
         default: mode_enables = 2'h3;
      endcase
   endfunction : mode_enables

   wire logic [1:0] en_now = mode_enables(mode);
   wire logic sw_mode = (mode == DCC_MODE_C1_MUX) ||
      (mode == DCC_MODE_MUX_BOTH) || (mode == DCC_MODE_C2_ONLY);
   wire logic [1:0] inv_sel_now = {sw_mode && sw, sw_mode && sw};
   wire logic common_ref = (mode == DCC_MODE_COMMON_REF) ||
      (mode == DCC_MODE_OUT_PINS);
   wire logic [1:0] noninv_sel_now = {1'b0, common_ref};
   wire logic ref2 = (mode == DCC_MODE_C2_ONLY) && sw;
   // reset mode turns every input pin analog
   wire logic [3:0] pin_mode_now = (mode == DCC_MODE_RESET) ? 4'hF :
      {en_now[1], en_now[1], en_now[0], en_now[0]};

   // ****************************************
   // output polarity and mismatch
   // ****************************************
   // polarity bits invert reported outputs
   wire logic [1:0] pol = {ctrl_reg[DCC_INV2_BIT], ctrl_reg[DCC_INV1_BIT]};
   wire logic [1:0] out_now = (sync2_reg ^ pol) & en_now;
   wire logic [1:0] mismatch = sample_reg ^ ref_reg;
   wire logic [1:0] sts_clr = (wr && hit_sts) ? pwdata[1:0] : 2'h0;
   // set wins over clear while the mismatch persists
   always_comb begin
      status_next = (status_reg & ~sts_clr) | mismatch;
   end

   wire logic [1:0] ie = {core_ctrl_reg[DCC_IE2_BIT],
      core_ctrl_reg[DCC_IE1_BIT]};
   wire logic peripheral_irq_master_enable = core_ctrl_reg[DCC_PERIPHERAL_IRQ_MASTER_ENABLE_BIT];
   wire logic global_irq_enable = core_ctrl_reg[DCC_GIE_BIT];
   // wake condition ignores the global enable
   wire logic wake_req = core_sleeping && peripheral_irq_master_enable && |(status_reg & ie);
   wire logic irq_now = |(status_reg & mask_reg);

   // ****************************************
   // read mux
   // ****************************************
   wire logic [7:0] cfg_rd = {sample_reg, ctrl_reg};
   wire logic [31:0] rd_now =
      hit_cfg ? {24'h00_0000, cfg_rd} :
      hit_sts ? {30'h0000_0000, status_reg} :
      hit_msk ? {30'h0000_0000, mask_reg} :
      hit_ctl ? {28'h000_0000, core_ctrl_reg} :
      hit_wak ? {31'h0000_0000, wake_seen_reg} : 32'h0000_0000;

   // ****************************************
   // wake sequencing
   // ****************************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         DCC_ST_RUN: if (wake_req) state_next = DCC_ST_NEXT;
         DCC_ST_NEXT: state_next = global_irq_enable ? DCC_ST_VEC : DCC_ST_RUN;
         // then vector when global enable set
         DCC_ST_VEC: state_next = DCC_ST_RUN;
         default: state_next = DCC_ST_RUN;
      endcase
   end

   // ****************************************
   // flops
   // ****************************************
   // all control state returns to reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= DCC_CFG_RST[5:0];
         core_ctrl_reg <= DCC_CORE_CTRL_RST;
         mask_reg <= DCC_MASK_RST;
      end else if (wr) begin
         if (hit_cfg) ctrl_reg <= pwdata[5:0];
         if (hit_ctl) core_ctrl_reg <= pwdata[3:0];
         if (hit_msk) mask_reg <= pwdata[1:0];
      end
   end

   // sampling runs on the free clock, sleep or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
         sample_reg <= 2'h0;
      end else begin
         sync1_reg <= raw_compare;
         sync2_reg <= sync1_reg;
         sample_reg <= out_now;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ref_reg <= 2'h0;
      else if (cfg_touch) ref_reg <= sample_reg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 2'h0;
         state_reg <= DCC_ST_RUN;
         wake_seen_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         state_reg <= state_next;
         if (wr && hit_wak) wake_seen_reg <= 1'b0;
         if (state_reg == DCC_ST_NEXT) wake_seen_reg <= 1'b1;
      end
   end

   // outputs from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         comp_enable <= 2'h0;
         noninv_sel <= 2'h0;
         inv_sel <= 2'h0;
         ref_to_c2_inv <= 1'b0;
         analog_pin_mode <= 4'hF;
         comp_pin_out <= 2'h0;
         comp_pin_oe_n <= 2'h3;
         core_wake <= 1'b0;
         core_exec_next <= 1'b0;
         core_vector <= 1'b0;
         irq <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit_any;
         prdata <= rd_now;
         comp_enable <= en_now;
         noninv_sel <= noninv_sel_now;
         inv_sel <= inv_sel_now;
         ref_to_c2_inv <= ref2;
         analog_pin_mode <= pin_mode_now;
         // pins driven only in mode 110
         comp_pin_out <= out_now;
         comp_pin_oe_n <= (mode == DCC_MODE_OUT_PINS) ? 2'h0 : 2'h3;
         core_wake <= wake_req;
         core_exec_next <= state_next == DCC_ST_NEXT;
         core_vector <= state_next == DCC_ST_VEC;
         irq <= irq_now;
      end
   end
endmodule : dcc_top

// ### dv/dcc_sva.sv
module dcc_sva (
   // bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pready,
   input wire logic pslverr,
   // comparator side
   input wire logic [1:0] comp_enable,
   input wire logic [3:0] analog_pin_mode,
   input wire logic [1:0] comp_pin_oe_n,
   // core side
   input wire logic core_sleeping,
   input wire logic core_wake,
   input wire logic core_exec_next,
   input wire logic core_vector
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_reset_state: assert property ($rose(presetn) |->
      comp_enable == 2'h0 && analog_pin_mode == 4'hF)
      else $error("reset state wrong");
   a_pins_mode: assert property (comp_pin_oe_n != 2'h3 |->
      comp_pin_oe_n == 2'h0 && comp_enable == 2'h3)
      else $error("pin drive outside output mode");
   a_pins_off: assert property (comp_enable == 2'h0 |->
      comp_pin_oe_n == 2'h3) else $error("pin driven while off");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_wake_cond: assert property (core_wake |-> $past(core_sleeping))
      else $error("wake while awake");
   a_vec_after: assert property (core_vector |-> $past(core_exec_next))
      else $error("vector before next instruction");
   a_exec_pulse: assert property (core_exec_next |=> !core_exec_next)
      else $error("next instruction pulse too long");
   // sleep must not power the comparators down
   a_sleep_hold: assert property (core_sleeping &&
      $past(core_sleeping, 4) |-> $stable(comp_enable))
      else $error("enable changed in sleep");
endmodule : dcc_sva
bind dcc_top dcc_sva u_dcc_sva (.pclk, .presetn, .pready, .pslverr,
   .comp_enable, .analog_pin_mode, .comp_pin_oe_n, .core_sleeping,
   .core_wake, .core_exec_next, .core_vector);

// ### dv/dcc_partner.sv
module dcc_partner (
   // from bench
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] level,
   input wire logic sleep_req,
   // design side
   input wire logic core_wake,
   output logic [1:0] raw_compare,
   output logic core_sleeping
);
   timeunit 1ns;
   timeprecision 1ns;
   // analog result, unrelated to the clock
   assign raw_compare = level;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_sleeping <= 1'b0;
      end else if (core_wake) begin
         core_sleeping <= 1'b0;
      end else if (sleep_req) begin
         core_sleeping <= 1'b1;
      end
   end
endmodule : dcc_partner

// ### dv/tb.sv
module tb;
   import dcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic sleep_req = 0, pready, pslverr, core_sleeping, core_wake, irq;
   logic core_exec_next, core_vector, ref_to_c2_inv;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [1:0] level = '0, raw_compare, comp_enable, noninv_sel, inv_sel;
   logic [1:0] comp_pin_out, comp_pin_oe_n;
   logic [3:0] analog_pin_mode;
   logic [1:0] en_t [8] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h0};
   logic [32:0] expq[$];
   int error_cnt = 0, tests_run = 0, n;
   initial forever #25 pclk = ~pclk;
   dcc_top u_dcc_top (.*);
   dcc_partner u_dcc_partner (.*);
   task chk(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task summarize;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
      int k;
      @(posedge pclk);
      if (!w) expq.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         error_cnt++;
         summarize();
      end
   endtask : apb
   // two sync flops, sample, flag and the registered output stage
   task settle;
      repeat (6) @(posedge pclk);
   endtask : settle
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         chk({pslverr, prdata}, expq.pop_front());
      end
   end
   initial begin
      void'($urandom(32'hf5ad));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, DCC_CFG_OFS, '0, 33'(DCC_CFG_RST));
      apb(0, 12'hFFC, '0, 33'h1_0000_0000);
      for (int m = 0; m < 8; m++) begin
         apb(1, DCC_CFG_OFS, 32'(m + 8), '0);
         settle();
         chk(33'(comp_enable), 33'(en_t[m]));
         chk(33'(comp_pin_oe_n), (m == 6) ? 33'h0 : 33'h3);
         chk(33'(analog_pin_mode), (m == 0) ? 33'hF : 33'({en_t[m][1],
            en_t[m][1], en_t[m][0], en_t[m][0]}));
         chk(33'(inv_sel), (m == 1 || m == 2 || m == 5) ? 33'h3 : 33'h0);
         chk(33'(noninv_sel), (m == 3 || m == 6) ? 33'h1 : 33'h0);
         chk(33'(ref_to_c2_inv), 33'(m == 5));
      end
      apb(1, DCC_CFG_OFS, 32'h24, '0);
      for (int i = 0; i < 6; i++) begin
         level <= 2'($urandom);
         settle();
         chk(33'(comp_pin_out), 33'({~level[1], level[0]}));
         apb(0, DCC_CFG_OFS, '0, {25'h0, ~level[1], level[0], 6'h24});
      end
      apb(1, DCC_IRQ_STATUS_OFS, 32'h3, '0);
      apb(1, DCC_IRQ_MASK_OFS, 32'h3, '0);
      level <= level ^ 2'h1;
      settle();
      chk(33'(irq), 33'h1);
      apb(1, DCC_IRQ_STATUS_OFS, 32'h3, '0);
      apb(0, DCC_IRQ_STATUS_OFS, '0, 33'h1);
      apb(1, DCC_IRQ_MASK_OFS, 32'h0, '0);
      settle();
      chk(33'(irq), 33'h0);
      apb(0, DCC_CFG_OFS, '0, {25'h0, ~level[1], level[0], 6'h24});
      apb(1, DCC_IRQ_STATUS_OFS, 32'h3, '0);
      apb(0, DCC_IRQ_STATUS_OFS, '0, 33'h0);
      apb(1, DCC_CORE_CTRL_OFS, 32'hF, '0);
      sleep_req <= 1'b1;
      @(posedge pclk);
      sleep_req <= 1'b0;
      level <= level ^ 2'h2;
      for (n = 0; n < 20 && core_exec_next !== 1'b1; n++) @(posedge pclk);
      chk(33'(n < 20), 33'h1);
      @(posedge pclk);
      chk(33'(core_vector), 33'h1);
      apb(0, DCC_WAKE_OFS, '0, 33'h1);
      summarize();
   end
endmodule : tb
